// file: design/mfs_map.vh
`ifndef MFS_MAP_VH
`define MFS_MAP_VH
// Register addresses of the two fault status registers.
`define MFS_ADDR_STATUS1 8'h41
`define MFS_ADDR_STATUS2 8'h42
// Reset values.
`define MFS_RST_STATUS1 8'h00
`define MFS_RST_STATUS2 8'h00
// First status register fields.
`define MFS_S1_V25 0
`define MFS_S1_CORE 1
`define MFS_S1_V33 2
`define MFS_S1_V5 3
`define MFS_S1_ZONE1 4
`define MFS_S1_ZONE2 5
`define MFS_S1_ZONE3 6
`define MFS_S1_SUMMARY 7
// Second status register fields.
`define MFS_S2_V12 0
`define MFS_S2_RSVD 1
`define MFS_S2_FAN_LO 2
`define MFS_S2_DIODE1 6
`define MFS_S2_DIODE2 7
`endif

// file: design/mfs_status.v
`timescale 1ns/1ps
`include "mfs_map.vh"
module mfs_status (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [7:0] v25_value,
  input wire [7:0] v25_low,
  input wire [7:0] v25_high,
  input wire [7:0] core_supply_input,
  input wire [7:0] core_low,
  input wire [7:0] core_high,
  input wire [7:0] v33_value,
  input wire [7:0] v33_low,
  input wire [7:0] v33_high,
  input wire [7:0] v5_value,
  input wire [7:0] v5_low,
  input wire [7:0] v5_high,
  input wire [7:0] v12_value,
  input wire [7:0] v12_low,
  input wire [7:0] v12_high,
  input wire [7:0] diode_one_temp,
  input wire [7:0] zone_one_low,
  input wire [7:0] zone_one_high,
  input wire [7:0] die_temp,
  input wire [7:0] zone_two_low,
  input wire [7:0] zone_two_high,
  input wire [7:0] diode_two_temp,
  input wire [7:0] zone_three_low,
  input wire [7:0] zone_three_high,
  input wire [63:0] speed_count,
  input wire [63:0] speed_minimum,
  input wire diode_one_fault,
  input wire diode_two_fault,
  output reg [7:0] fault_status1,
  output reg [7:0] fault_status2
);
  // Live fault conditions, one wire per comparison so each limit edge stays visible.
  wire v25_under;
  wire v25_over;
  wire core_under;
  wire core_over;
  wire v33_under;
  wire v33_over;
  wire v5_under;
  wire v5_over;
  wire v12_under;
  wire v12_over;
  wire zone_one_under;
  wire zone_one_over;
  wire zone_two_under;
  wire zone_two_over;
  wire zone_three_under;
  wire zone_three_over;
  wire zone_one_limit_flag;
  wire zone_two_limit_flag;
  wire zone_three_limit_flag;
  wire diode_one_fault_flag;
  wire diode_two_fault_flag;
  wire fan_one_stall_flag;
  wire fan_two_stall_flag;
  wire fan_three_stall_flag;
  wire fan_four_stall_flag;
  wire [3:0] fan_live;
  wire [7:0] live1;
  wire [7:0] live2;
  wire rd1;
  wire rd2;
  wire rd_other;
  wire [7:0] s1_d;
  wire [7:0] s2_d;
  wire [7:0] rdata_d;

  // Voltage windows.
  // On these four rails a reading equal to the low limit already counts as a fault.
  assign v25_under = (v25_value <= v25_low);
  assign v25_over = (v25_value > v25_high);
  assign core_under = (core_supply_input <= core_low);
  assign core_over = (core_supply_input > core_high);
  assign v33_under = (v33_value <= v33_low);
  assign v33_over = (v33_value > v33_high);
  assign v5_under = (v5_value <= v5_low);
  assign v5_over = (v5_value > v5_high);

  // Strict 12V window.
  // Unlike the other rails, a 12V reading equal to its low limit is still in range.
  assign v12_under = (v12_value < v12_low);
  assign v12_over = (v12_value > v12_high);

  // Signed zone compares.
  // Limits below zero degrees would look huge if compared unsigned.
  // Zone one and zone two windows.
  assign zone_one_under = ($signed(diode_one_temp) <= $signed(zone_one_low));
  assign zone_one_over = ($signed(diode_one_temp) > $signed(zone_one_high));
  assign zone_two_under = ($signed(die_temp) <= $signed(zone_two_low));
  assign zone_two_over = ($signed(die_temp) > $signed(zone_two_high));
  // Zone three window.
  // Zone three uses its own low limit, so the three zones stay independent.
  assign zone_three_under = ($signed(diode_two_temp) <= $signed(zone_three_low));
  assign zone_three_over = ($signed(diode_two_temp) > $signed(zone_three_high));

  assign diode_one_fault_flag = diode_one_fault;
  assign diode_two_fault_flag = diode_two_fault;

  // A broken diode gives a meaningless reading, so its zone is flagged as well.
  assign zone_one_limit_flag = zone_one_under | zone_one_over | diode_one_fault_flag;
  assign zone_two_limit_flag = zone_two_under | zone_two_over;
  assign zone_three_limit_flag = zone_three_under | zone_three_over | diode_two_fault_flag;

  // Speed stall compare.
  // A slow fan gives a long period, so a count above the minimum means a stall.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_fan
      assign fan_live[g] = (speed_count[16*g +: 16] > speed_minimum[16*g +: 16]);
    end
  endgenerate

  assign fan_one_stall_flag = fan_live[0];
  assign fan_two_stall_flag = fan_live[1];
  assign fan_three_stall_flag = fan_live[2];
  assign fan_four_stall_flag = fan_live[3];

  assign live1[`MFS_S1_V25] = v25_under | v25_over;
  assign live1[`MFS_S1_CORE] = core_under | core_over;
  assign live1[`MFS_S1_V33] = v33_under | v33_over;
  assign live1[`MFS_S1_V5] = v5_under | v5_over;
  assign live1[`MFS_S1_ZONE1] = zone_one_limit_flag;
  assign live1[`MFS_S1_ZONE2] = zone_two_limit_flag;
  assign live1[`MFS_S1_ZONE3] = zone_three_limit_flag;
  // The summary bit has no live source of its own; it follows register two.
  assign live1[`MFS_S1_SUMMARY] = 1'b0;

  assign live2[`MFS_S2_V12] = v12_under | v12_over;
  assign live2[`MFS_S2_RSVD] = 1'b0;
  assign live2[`MFS_S2_FAN_LO] = fan_one_stall_flag;
  assign live2[`MFS_S2_FAN_LO + 1] = fan_two_stall_flag;
  assign live2[`MFS_S2_FAN_LO + 2] = fan_three_stall_flag;
  assign live2[`MFS_S2_FAN_LO + 3] = fan_four_stall_flag;
  assign live2[`MFS_S2_DIODE1] = diode_one_fault_flag;
  assign live2[`MFS_S2_DIODE2] = diode_two_fault_flag;

  // Writes are not decoded.
  // A read strobe that comes with a write strobe is dropped whole, so it neither
  // clears flags nor disturbs the read data.
  assign rd1 = reg_rd & ~reg_wr & (reg_addr == `MFS_ADDR_STATUS1);
  assign rd2 = reg_rd & ~reg_wr & (reg_addr == `MFS_ADDR_STATUS2);
  assign rd_other = reg_rd & ~reg_wr & ~rd1 & ~rd2;

  // Independent flags.
  // Each flag except the summary and reserved bits is its own latch, so a read never loses a fault that is live at that edge.
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_flag
      if (b == `MFS_S1_SUMMARY) begin : g_sum
        assign s1_d[b] = (|s2_d) | live1[b];
      end else begin : g_one
        assign s1_d[b] = (fault_status1[b] & ~rd1) | live1[b];
      end
      if (b == `MFS_S2_RSVD) begin : g_rsvd
        assign s2_d[b] = live2[b];
      end else begin : g_two
        assign s2_d[b] = (fault_status2[b] & ~rd2) | live2[b];
      end
    end
  endgenerate

  // Read data shows the value before any clear takes effect, and holds between reads.
  assign rdata_d = rd1 ? fault_status1 :
    rd2 ? fault_status2 :
    rd_other ? 8'h00 : reg_rdata;

  always @(posedge clk_sys) begin
    if (rst) begin
      fault_status1 <= `MFS_RST_STATUS1;
    end else if (clk_en) begin
      fault_status1 <= s1_d;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      fault_status2 <= `MFS_RST_STATUS2;
    end else if (clk_en) begin
      fault_status2 <= s2_d;
    end
  end

  // With the enable low the read is not taken at all, so no flag is cleared unseen.
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= rdata_d;
    end
  end
endmodule

// file: tb/mfs_host.sv
`timescale 1ns/1ps
module mfs_host (
  input wire clk_sys,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_rd = 1'h0,
  output logic reg_wr = 1'h0
);
  // Released lines show the inverse address so a stale value is never read as valid.
  task automatic acc(input logic [7:0] a, input logic r, w);
    @(negedge clk_sys);
    {reg_addr, reg_wdata, reg_rd, reg_wr} = {a, ~a, r, w};
    @(negedge clk_sys);
    {reg_addr, reg_rd, reg_wr} = {~a, 2'h0};
  endtask
endmodule

// file: tb/mfs_status_chk.sv
`timescale 1ns/1ps
module mfs_status_chk (
  input wire clk_sys, rst, clk_en, reg_rd, reg_wr, diode_one_fault, diode_two_fault,
  input wire [7:0] reg_addr, reg_rdata, fault_status1, fault_status2
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  rsvd_zero_a: assert property (!fault_status2[1]) else $error("rsvd");
  summary_bit_a: assert property (fault_status1[7] == |fault_status2) else $error("sum");
  diode_one_a: assert property (clk_en && diode_one_fault |=>
    fault_status2[6] && fault_status1[4]) else $error("d1");
  diode_two_a: assert property (clk_en && diode_two_fault |=>
    fault_status2[7] && fault_status1[6]) else $error("d2");
  flag_hold_a: assert property (!reg_rd |=>
    &(fault_status1 | ~$past(fault_status1))) else $error("hold");
  read_one_a: assert property (clk_en && reg_rd && !reg_wr && reg_addr == 8'h41 |=>
    reg_rdata == $past(fault_status1)) else $error("rd1");
  read_two_a: assert property (clk_en && reg_rd && !reg_wr && reg_addr == 8'h42 |=>
    reg_rdata == $past(fault_status2)) else $error("rd2");
  write_none_a: assert property (reg_wr |=> $stable(reg_rdata)) else $error("wr");
endmodule

// file: tb/tb_mfs_status.sv
`timescale 1ns/1ps
module tb_mfs_status;
  logic clk_sys = 1'h0, rst = 1'h1, clk_en = 1'h1, reg_rd, reg_wr;
  logic diode_one_fault = 1'h0, diode_two_fault = 1'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fault_status1, fault_status2;
  logic [7:0] v = 8'hc0, t = 8'h00, lo = 8'h40, hi = 8'hc0, zl = 8'hf6, zh = 8'h32;
  logic [63:0] speed_count = {4{16'h0100}}, speed_minimum = {4{16'h0100}};
  wire [7:0] v25_value = v, core_supply_input = v, v33_value = v, v5_value = v, v12_value = v;
  wire [7:0] v25_low = lo, core_low = lo, v33_low = lo, v5_low = lo, v12_low = lo;
  wire [7:0] v25_high = hi, core_high = hi, v33_high = hi, v5_high = hi, v12_high = hi;
  wire [7:0] diode_one_temp = t, die_temp = t, diode_two_temp = t, zone_one_low = zl;
  wire [7:0] zone_two_low = zl, zone_three_low = zl, zone_one_high = zh;
  wire [7:0] zone_two_high = zh, zone_three_high = zh;
  int n_fail = 0, n_checks = 0;
  // Row: volts, temp, speed count, diode faults, expected status one, status two.
  logic [51:0] rows [9] = '{52'hc000010000000, 52'h4000010000f00, 52'h3f00010008f01,
    52'hc100010008f01, 52'hc0f6010007000, 52'hc033010007000, 52'hc03201010803c,
    52'hc000010019040, 52'hc00001002c080};
  mfs_status u_mfs_status (.*);
  mfs_host u_mfs_host (.*);
  task automatic chk(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    u_mfs_host.acc(a, 1'h1, 1'h0);
    chk(reg_rdata, e);
  endtask
  task automatic put(input logic [51:0] r);
    @(negedge clk_sys);
    {v, t, speed_count, diode_two_fault, diode_one_fault} = {r[51:36], {4{r[35:20]}}, r[17:16]};
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #2.5 clk_sys = ~clk_sys;
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'h0;
    @(negedge clk_sys);
    chk(fault_status1, 8'h00);
    chk(fault_status2, 8'h00);
    chk(reg_rdata, 8'h00);
    $display("reset done");
    foreach (rows[i]) begin
      put(rows[i]);
      put(rows[0]);
      rd(8'h41, rows[i][15:8]);
      rd(8'h42, rows[i][7:0]);
      rd(8'h41, 8'h00);
    end
    $display("rows done");
    put(rows[1]);
    rd(8'h41, 8'h0f);
    u_mfs_host.acc(8'h41, 1'h0, 1'h1);
    u_mfs_host.acc(8'h41, 1'h1, 1'h1);
    chk(reg_rdata, 8'h0f);
    chk(fault_status1, 8'h0f);
    put(rows[0]);
    rd(8'h41, 8'h0f);
    rd(8'h41, 8'h00);
    put(rows[1]);
    rd(8'h41, 8'h0f);
    chk(fault_status1, 8'h0f);
    fork
      put(rows[4]);
      u_mfs_host.acc(8'h41, 1'h1, 1'h0);
    join
    chk(reg_rdata, 8'h0f);
    chk(fault_status1, 8'h70);
    put(rows[0]);
    rd(8'h41, 8'h70);
    rd(8'h41, 8'h00);
    $display("awkward done");
    @(negedge clk_sys);
    clk_en = 1'h0;
    put(rows[2]);
    put(rows[2]);
    chk(fault_status1, 8'h00);
    chk(fault_status2, 8'h00);
    rd(8'h42, 8'h00);
    @(negedge clk_sys);
    clk_en = 1'h1;
    put(rows[0]);
    rd(8'h42, 8'h01);
    chk(fault_status1, 8'h0f);
    $display("freeze done");
    @(negedge clk_sys);
    rst = 1'h1;
    @(negedge clk_sys);
    rst = 1'h0;
    chk(fault_status1, 8'h00);
    chk(fault_status2, 8'h00);
    chk(reg_rdata, 8'h00);
    $display("mid reset done");
    stop_test;
  end
endmodule
bind mfs_status mfs_status_chk u_mfs_status_chk (.*);
